// ==== logic/fast_output_pwm_match.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fast_out_cfg.svh"
module fast_output_pwm_match #(
  parameter int unsigned CLK_HZ = `FO_CLK_HZ,
  parameter int unsigned PHASE_W = `FO_PHASE_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire fast_out_pkg::mode_type i_mode_one,
  input wire fast_out_pkg::mode_type i_mode_two,
  input wire logic i_direct_drive_bit_one,
  input wire logic i_direct_drive_bit_two,
  input wire fast_out_pkg::pwm_cfg_type i_pwm_run_one,
  input wire fast_out_pkg::pwm_cfg_type i_pwm_run_two,
  input wire fast_out_pkg::pwm_cfg_type i_pwm_stop_one,
  input wire fast_out_pkg::pwm_cfg_type i_pwm_stop_two,
  input wire logic i_stop_mode,
  input wire logic i_stop_hold,
  input wire logic i_download,
  input wire logic [31:0] i_accum_counter_one,
  input wire logic [31:0] i_accum_counter_two,
  input wire logic [31:0] i_match_value_a_counter_one,
  input wire logic [31:0] i_match_value_b_counter_one,
  input wire logic [31:0] i_match_value_a_counter_two,
  input wire logic [31:0] i_match_value_b_counter_two,
  input wire logic i_output_reset_counter_one,
  input wire logic i_output_reset_counter_two,
  input wire fast_out_pkg::action_type i_match_action_one,
  input wire fast_out_pkg::action_type i_match_action_two,
  output logic o_fast_output_one,
  output logic o_fast_output_two,
  output logic o_fast_output_one_level,
  output logic o_fast_output_two_level
);
  import fast_out_pkg::*;

  localparam int unsigned NCH = 2;

  if (PHASE_W < 2 || PHASE_W > 31) begin : g_bad_width
    $error("PHASE_W must lie between 2 and 31.");
  end

  function automatic logic match_hit(input logic [31:0] acc, input logic [31:0] a,
                                     input logic [31:0] b);
    match_hit = (acc == a) || (acc == b);
  endfunction

  function automatic logic cfg_live(input pwm_cfg_type c);
    cfg_live = (c.duty != 32'h0) && (c.freq != 32'h0);
  endfunction

  mode_type mode [NCH];
  action_type act [NCH];
  logic [31:0] acc [NCH];
  logic [31:0] ma [NCH];
  logic [31:0] mb [NCH];
  pwm_cfg_type run_cfg [NCH];
  pwm_cfg_type stop_cfg [NCH];
  pwm_cfg_type sel_cfg [NCH];
  logic [NCH-1:0] direct;
  logic [NCH-1:0] out_rst;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] match_event;
  logic [NCH-1:0] pwm_w;
  logic [NCH-1:0] run_w;
  logic [NCH-1:0] en_w;
  logic [NCH-1:0] prev_hit_q, prev_hit_d;
  logic [NCH-1:0] match_q, match_d;
  logic [NCH-1:0] armed_q, armed_d;
  logic [NCH-1:0] out_q, out_d;
  logic [NCH-1:0] lvl_q, lvl_d;

  assign mode[0] = i_mode_one;
  assign mode[1] = i_mode_two;
  assign act[0] = i_match_action_one;
  assign act[1] = i_match_action_two;
  assign acc[0] = i_accum_counter_one;
  assign acc[1] = i_accum_counter_two;
  assign ma[0] = i_match_value_a_counter_one;
  assign ma[1] = i_match_value_a_counter_two;
  assign mb[0] = i_match_value_b_counter_one;
  assign mb[1] = i_match_value_b_counter_two;
  assign run_cfg[0] = i_pwm_run_one;
  assign run_cfg[1] = i_pwm_run_two;
  assign stop_cfg[0] = i_pwm_stop_one;
  assign stop_cfg[1] = i_pwm_stop_two;
  assign direct[0] = i_direct_drive_bit_one;
  assign direct[1] = i_direct_drive_bit_two;
  assign out_rst[0] = i_output_reset_counter_one;
  assign out_rst[1] = i_output_reset_counter_two;

  // Counter compare: an event is the first cycle in which either match value is met.
  always_comb begin
    hit = '0;
    match_event = '0;
    prev_hit_d = '0;
    match_d = match_q;
    for (int i = 0; i < NCH; i++) begin
      hit[i] = match_hit(acc[i], ma[i], mb[i]);
      match_event[i] = hit[i] && !prev_hit_q[i];
      prev_hit_d[i] = hit[i];
      if (out_rst[i]) begin
        match_d[i] = 1'b0;
      end
      if (match_event[i]) begin
        unique case (act[i])
          ACT_ON: begin
            match_d[i] = 1'b1;
          end
          ACT_OFF: begin
            match_d[i] = 1'b0;
          end
          ACT_TOGGLE: begin
            match_d[i] = !match_q[i];
          end
          default: begin
            match_d[i] = match_q[i];
          end
        endcase
      end
    end
  end

  // PWM parameter selection between run values and stop-mode values.
  always_comb begin
    armed_d = armed_q;
    run_w = '0;
    en_w = '0;
    for (int i = 0; i < NCH; i++) begin
      sel_cfg[i] = run_cfg[i];
      if (i_download) begin
        armed_d[i] = 1'b0;
      end else if (cfg_live(run_cfg[i])) begin
        armed_d[i] = 1'b1;
      end
      if (i_stop_mode && i_stop_hold) begin
        run_w[i] = 1'b0;
        en_w[i] = 1'b1;
      end else if (i_stop_mode) begin
        sel_cfg[i] = stop_cfg[i];
        run_w[i] = 1'b1;
        en_w[i] = cfg_live(stop_cfg[i]);
      end else begin
        run_w[i] = 1'b1;
        en_w[i] = armed_q[i];
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_pwm
    pwm_channel #(
      .CLK_HZ(CLK_HZ),
      .PHASE_W(PHASE_W)
    ) u_pwm (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_cfg(sel_cfg[g]),
      .i_run(run_w[g]),
      .i_enable(en_w[g]),
      .o_pwm(pwm_w[g])
    );
  end

  // Output source selection per mode; the stepper source is not fitted and stays low.
  always_comb begin
    out_d = '0;
    lvl_d = out_q;
    for (int i = 0; i < NCH; i++) begin
      unique case (mode[i])
        MODE_PLAIN: begin
          out_d[i] = direct[i];
        end
        MODE_PWM: begin
          out_d[i] = pwm_w[i];
        end
        MODE_MATCH: begin
          out_d[i] = match_q[i];
        end
        MODE_STEPPER: begin
          out_d[i] = 1'b0;
        end
        default: begin
          out_d[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_hit_q <= '0;
      match_q <= '0;
      armed_q <= '0;
      out_q <= '0;
      lvl_q <= '0;
    end else begin
      prev_hit_q <= prev_hit_d;
      match_q <= match_d;
      armed_q <= armed_d;
      out_q <= out_d;
      lvl_q <= lvl_d;
    end
  end

  assign o_fast_output_one = out_q[0];
  assign o_fast_output_two = out_q[1];
  assign o_fast_output_one_level = lvl_q[0];
  assign o_fast_output_two_level = lvl_q[1];

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  for (genvar c = 0; c < NCH; c++) begin : g_chk
    sequence s_event;
      hit[c] && !prev_hit_q[c];
    endsequence

    sequence s_event_on_in_match;
      s_event ##0 act[c] == ACT_ON ##1 mode[c] == MODE_MATCH;
    endsequence

    match_edge_a: assert property (
      match_hit(acc[c], ma[c], mb[c]) && !prev_hit_q[c] |-> match_event[c])
      else $error("Met match value raised no event.");

    match_drive_a: assert property (s_event_on_in_match |=> out_q[c])
      else $error("Match event did not turn the output on.");

    match_off_a: assert property (s_event ##0 act[c] == ACT_OFF |=> !match_q[c])
      else $error("Match event did not turn the output off.");

    match_toggle_a: assert property (
      s_event ##0 act[c] == ACT_TOGGLE |=> match_q[c] != $past(match_q[c]))
      else $error("Match event did not invert the output.");

    match_follow_a: assert property (mode[c] == MODE_MATCH |=> out_q[c] == $past(match_q[c]))
      else $error("Match mode output left its comparison state.");

    plain_drive_a: assert property (mode[c] == MODE_PLAIN |=> out_q[c] == $past(direct[c]))
      else $error("Plain mode output differs from its drive bit.");

    reset_off_a: assert property (out_rst[c] && !match_event[c] |=> !match_q[c])
      else $error("Output reset did not force the match output off.");

    reset_keep_a: assert property (!out_rst[c] && !match_event[c] |=> $stable(match_q[c]))
      else $error("Match output changed without an event.");

    level_track_a: assert property (out_q[c] != $past(out_q[c]) |=> lvl_q[c] == $past(out_q[c]))
      else $error("Level status lags the output by more than a cycle.");

    unarmed_low_a: assert property (!armed_q[c] && !i_stop_mode |=> !pwm_w[c])
      else $error("PWM ran before both parameters were set.");

    stop_low_a: assert property (
      i_stop_mode && !i_stop_hold && !cfg_live(stop_cfg[c]) |=> !pwm_w[c])
      else $error("Stop mode PWM ran with a zero stop value.");

    stop_hold_a: assert property (i_stop_mode && i_stop_hold |=> $stable(pwm_w[c]))
      else $error("Stop mode hold let the PWM level change.");

    stepper_low_a: assert property (mode[c] == MODE_STEPPER |=> !out_q[c])
      else $error("Stepper mode drove the output high.");

    pwm_route_a: assert property (mode[c] == MODE_PWM |=> out_q[c] == $past(pwm_w[c]))
      else $error("PWM mode output differs from its channel.");

    held_equal_a: assert property (
      hit[c] && prev_hit_q[c] && !out_rst[c] |=> $stable(match_q[c]))
      else $error("Held match value raised a second event.");

    event_wins_a: assert property (
      s_event ##0 (out_rst[c] && act[c] == ACT_ON) |=> match_q[c])
      else $error("Output reset overrode a match event.");

    download_clear_a: assert property (i_download |=> !armed_q[c])
      else $error("Download left the PWM armed.");

    rearm_a: assert property (
      !i_download && cfg_live(run_cfg[c]) |=> armed_q[c])
      else $error("Nonzero run parameters did not arm the PWM.");

    run_full_a: assert property (
      !i_stop_mode && armed_q[c] && run_cfg[c].duty >= 32'(`FO_DUTY_FULL) |=> pwm_w[c])
      else $error("Full run duty did not drive the channel high.");

    run_zero_a: assert property (
      !i_stop_mode && run_cfg[c].duty == 32'h0 |=> !pwm_w[c])
      else $error("Zero run duty let the channel go high.");
  end
endmodule
`default_nettype wire

// ==== logic/pwm_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fast_out_cfg.svh"
module pwm_channel #(
  parameter int unsigned CLK_HZ = `FO_CLK_HZ,
  parameter int unsigned PHASE_W = `FO_PHASE_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire fast_out_pkg::pwm_cfg_type i_cfg,
  input wire logic i_run,
  input wire logic i_enable,
  output logic o_pwm
);
  import fast_out_pkg::*;

  localparam logic [PHASE_W-1:0] MOD = PHASE_W'(CLK_HZ);
  localparam logic [31:0] FULL = 32'(`FO_DUTY_FULL);

  if (CLK_HZ == 0 || 64'(CLK_HZ) >= (64'd1 << PHASE_W)) begin : g_bad_clk
    $error("CLK_HZ does not fit the phase accumulator.");
  end

  logic [PHASE_W-1:0] phase_q, phase_d;
  logic pwm_d;
  logic [PHASE_W:0] sum;
  logic [31:0] step;
  logic [63:0] lhs, rhs;

  // While i_run is high the phase advances by the frequency, capped at the clock rate, each cycle and wraps at the clock rate.
  always_comb begin
    step = (i_cfg.freq > 32'(CLK_HZ)) ? 32'(CLK_HZ) : i_cfg.freq;
    sum = {1'b0, phase_q} + (PHASE_W + 1)'(step);
    lhs = 64'(phase_q) * 64'(FULL);
    rhs = 64'(i_cfg.duty) * 64'(CLK_HZ);
    phase_d = phase_q;
    pwm_d = o_pwm;
    if (i_run) begin
      phase_d = (sum >= {1'b0, MOD}) ? PHASE_W'(sum - {1'b0, MOD}) : sum[PHASE_W-1:0];
      if (i_cfg.duty >= FULL) begin
        pwm_d = 1'b1;
      end else if (i_cfg.duty == 32'h0 || i_cfg.freq == 32'h0) begin
        pwm_d = 1'b0;
      end else begin
        pwm_d = (lhs < rhs);
      end
    end
    if (!i_enable) begin
      pwm_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q <= '0;
      o_pwm <= `FO_RESET_LEVEL;
    end else begin
      phase_q <= phase_d;
      o_pwm <= pwm_d;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  full_on_a: assert property (i_run && i_enable && i_cfg.duty >= FULL |=> o_pwm)
    else $error("Full duty did not drive the output high.");
  zero_off_a: assert property (i_run && i_cfg.duty == 32'h0 |=> !o_pwm)
    else $error("Zero duty did not hold the output low.");
  phase_range_a: assert property (phase_q < MOD)
    else $error("Phase left its period range.");
  hold_level_a: assert property (!i_run && i_enable |=> $stable(o_pwm))
    else $error("Held output changed level.");
endmodule
`default_nettype wire

// ==== pkg/fast_out_cfg.svh ====
`ifndef FAST_OUT_CFG_SVH
`define FAST_OUT_CFG_SVH

// Timing clock rate in hertz and its period in nanoseconds.
`define FO_CLK_HZ 200000000
`define FO_CLK_PERIOD_NS 5
// Duty value that means a permanently high output.
`define FO_DUTY_FULL 32000
// Width of the phase accumulator that spans one output period.
`define FO_PHASE_W 28
// Reset level of each PWM channel output.
`define FO_RESET_LEVEL 1'b0

`endif

// ==== pkg/fast_out_pkg.sv ====
package fast_out_pkg;

  typedef enum logic [3:0] {
    MODE_PLAIN = 4'h1,
    MODE_PWM = 4'h2,
    MODE_MATCH = 4'h4,
    MODE_STEPPER = 4'h8
  } mode_type;

  typedef enum logic [2:0] {
    ACT_ON = 3'h1,
    ACT_OFF = 3'h2,
    ACT_TOGGLE = 3'h4
  } action_type;

  typedef struct packed {
    logic [31:0] duty;
    logic [31:0] freq;
  } pwm_cfg_type;

endpackage

// ==== testbench/fast_output_pwm_match_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module fast_output_pwm_match_tb;
  import fast_out_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mode_type m1 = MODE_PLAIN, m2 = MODE_PLAIN;
  logic d1 = 1'b0, d2 = 1'b0, stop = 1'b0, hold = 1'b0, dl = 1'b0, rs1 = 1'b0, rs2 = 1'b0;
  pwm_cfg_type r1 = '0, r2 = '0, s1 = '0, s2 = '0;
  logic [31:0] ac1 = 32'h0, ac2 = 32'h0;
  action_type a1 = ACT_ON, a2 = ACT_ON;
  logic q1, q2, l1, l2;
  logic [31:0] hi1, per1, hi2, per2;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] ma = 32'h10;
  logic [31:0] mb = 32'h20;
  always #2.5 clk = ~clk;
  fast_output_pwm_match #(.CLK_HZ(1000), .PHASE_W(28)) dut (.i_mclk(clk), .i_rst_n(rst_n),
    .i_mode_one(m1), .i_mode_two(m2), .i_direct_drive_bit_one(d1), .i_direct_drive_bit_two(d2),
    .i_pwm_run_one(r1), .i_pwm_run_two(r2), .i_pwm_stop_one(s1), .i_pwm_stop_two(s2),
    .i_stop_mode(stop), .i_stop_hold(hold), .i_download(dl),
    .i_accum_counter_one(ac1), .i_accum_counter_two(ac2),
    .i_match_value_a_counter_one(ma), .i_match_value_b_counter_one(mb),
    .i_match_value_a_counter_two(ma), .i_match_value_b_counter_two(mb),
    .i_output_reset_counter_one(rs1), .i_output_reset_counter_two(rs2),
    .i_match_action_one(a1), .i_match_action_two(a2),
    .o_fast_output_one(q1), .o_fast_output_two(q2),
    .o_fast_output_one_level(l1), .o_fast_output_two_level(l2));
  load_model ld1 (.i_mclk(clk), .i_pin(q1), .o_high(hi1), .o_period(per1));
  load_model ld2 (.i_mclk(clk), .i_pin(q2), .o_high(hi2), .o_period(per2));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Pins and their status copies together, after the pipeline settles.
  task automatic chk_out(input logic e1, input logic e2);
    cyc(4);
    check(32'({q1, q2, l1, l2}), 32'({e1, e2, e1, e2}));
  endtask
  task automatic pwm(input logic [31:0] h1, input logic [31:0] p1, input logic [31:0] h2,
      input logic [31:0] p2);
    cyc(30);
    check(hi1, h1);
    check(per1, p1);
    check(hi2, h2);
    check(per2, p2);
  endtask
  task automatic hit(input logic [31:0] v1, input logic [31:0] v2);
    cyc(1);
    ac1 = v1;
    ac2 = v2;
    cyc(1);
    ac1 = 32'h0;
    ac2 = 32'h0;
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
  initial begin
    cyc(10);
    rst_n = 1'b1;
    chk_out(1'b0, 1'b0);
    d1 = 1'b1;
    chk_out(1'b1, 1'b0);
    d1 = 1'b0;
    d2 = 1'b1;
    chk_out(1'b0, 1'b1);
    m2 = MODE_STEPPER;
    chk_out(1'b0, 1'b0);
    m1 = MODE_MATCH;
    m2 = MODE_MATCH;
    hit(ma, 32'h0);
    chk_out(1'b1, 1'b0);
    a1 = ACT_TOGGLE;
    a2 = ACT_TOGGLE;
    hit(mb, mb);
    chk_out(1'b0, 1'b1);
    cyc(1);
    ac1 = ma;
    chk_out(1'b1, 1'b1);
    chk_out(1'b1, 1'b1);
    ac1 = 32'h0;
    rs2 = 1'b1;
    chk_out(1'b1, 1'b0);
    rs2 = 1'b0;
    chk_out(1'b1, 1'b0);
    a1 = ACT_OFF;
    a2 = ACT_ON;
    hit(mb, ma);
    chk_out(1'b0, 1'b1);
    mb = 32'h30;
    a1 = ACT_ON;
    a2 = ACT_OFF;
    hit(32'h30, 32'h20);
    chk_out(1'b1, 1'b1);
    rs1 = 1'b1;
    hit(ma, 32'h0);
    chk_out(1'b0, 1'b1);
    rs1 = 1'b0;
    chk_out(1'b0, 1'b1);
    m1 = MODE_PWM;
    m2 = MODE_PWM;
    r1 = '{32'h0, 32'h64};
    chk_out(1'b0, 1'b0);
    r1 = '{32'h3E80, 32'h64};
    r2 = '{32'h5DC0, 32'hFA};
    pwm(32'h5, 32'hA, 32'h3, 32'h4);
    r1 = '{32'h2580, 32'hFA};
    pwm(32'h1, 32'h4, 32'h3, 32'h4);
    r1 = '{32'h7D00, 32'h64};
    r2 = '{32'h0, 32'hFA};
    repeat (3) chk_out(1'b1, 1'b0);
    stop = 1'b1;
    hold = 1'b1;
    r1 = '{32'h0, 32'h64};
    r2 = '{32'h7D00, 32'hFA};
    repeat (2) chk_out(1'b1, 1'b0);
    hold = 1'b0;
    s1 = '{32'h0, 32'h64};
    s2 = '{32'h3E80, 32'h0};
    repeat (2) chk_out(1'b0, 1'b0);
    s1 = '{32'h3E80, 32'h64};
    s2 = '{32'h5DC0, 32'hFA};
    pwm(32'h5, 32'hA, 32'h3, 32'h4);
    stop = 1'b0;
    r1 = '{32'h3E80, 32'h64};
    r2 = '{32'h5DC0, 32'hFA};
    dl = 1'b1;
    repeat (2) chk_out(1'b0, 1'b0);
    dl = 1'b0;
    pwm(32'h5, 32'hA, 32'h3, 32'h4);
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== testbench/load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Load on one output pin: measures the last full period and its high time.
module load_model (
  input wire logic i_mclk,
  input wire logic i_pin,
  output logic [31:0] o_high,
  output logic [31:0] o_period
);
  logic prev_q = 1'b0;
  logic [31:0] cnt_q = 32'h0;
  logic [31:0] hcnt_q = 32'h0;
  initial o_high = 32'h0;
  initial o_period = 32'h0;
  always @(posedge i_mclk) begin
    prev_q <= i_pin;
    if (i_pin === 1'b1 && prev_q === 1'b0) begin
      o_period <= cnt_q;
      o_high <= hcnt_q;
      cnt_q <= 32'h1;
      hcnt_q <= 32'h1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      hcnt_q <= hcnt_q + {31'h0, i_pin};
    end
  end
endmodule
`default_nettype wire
